// ### hw/bss_map.vh
// register offsets, fields, channel numbers, sample width and last sector number of the back-emf sampling sequencer
`ifndef BSS_MAP_VH
`define BSS_MAP_VH
// ****************************************************************
// register byte offsets
// ****************************************************************
`define BSS_REG_CTRL        8'h00
`define BSS_REG_SECTOR      8'h04
`define BSS_REG_EMF         8'h08
`define BSS_REG_BUSV        8'h0C
`define BSS_REG_BUSI        8'h10
`define BSS_REG_STATUS      8'h14
`define BSS_REG_IRQ_STAT    8'h18
`define BSS_REG_IRQ_EN      8'h1C
`define BSS_REG_IRQ_CLR     8'h20
// ****************************************************************
// control fields
// ****************************************************************
`define BSS_CTRL_ENABLE     0
`define BSS_CTRL_DIAGONAL   1
`define BSS_CTRL_SEC_CUR    2
`define BSS_CTRL_STEP       3
`define BSS_CTRL_RESET      4'h0
// ****************************************************************
// interrupt bits
// ****************************************************************
`define BSS_IRQ_EMF_DONE    0
`define BSS_IRQ_BUS_DONE    1
`define BSS_IRQ_ZERO_CROSS  2
`define BSS_IRQ_TRIG_DROP   3
`define BSS_IRQ_W           4
// ****************************************************************
// converter channels
// ****************************************************************
`define BSS_CH_BUS_VOLT     4'd11
`define BSS_CH_BUS_CUR      4'd14
`define BSS_CH_PHASE_A      4'd10
`define BSS_CH_PHASE_B      4'd3
`define BSS_CH_PHASE_C      4'd7
// ****************************************************************
// sample width and last sector number
// ****************************************************************
`define BSS_SAMPLE_W        12
`define BSS_SECTOR_LAST     3'd5
`endif

// ### hw/bss_sector_map.v
// sector decode: switch pattern and idle phase input channel
`timescale 1ns/1ps
module bss_sector_map (
    input  wire [2:0] commutation_sector_i,
    input  wire       diagonal_switching_select_i,
    output reg  [5:0] gate_pattern_o,
    output reg  [3:0] emf_channel_o,
    output reg  [1:0] idle_phase_o
);
`include "bss_map.vh"
    // ****************************************************************
    // sector decode
    // ****************************************************************
    // gate order {c_hi,c_lo,b_hi,b_lo,a_hi,a_lo}: per leg 10 drives the top
    // switch, 01 the bottom one, 00 leaves the idle leg floating for sensing
    reg [5:0] hi_lo;
    always @* begin
        hi_lo = 6'h00;
        idle_phase_o = 2'd0;
        case (commutation_sector_i)
            3'd0: begin
                hi_lo = 6'b00_01_10; // a high, b low
                idle_phase_o = 2'd2;
            end
            3'd1: begin
                hi_lo = 6'b01_00_10; // a high, c low
                idle_phase_o = 2'd1;
            end
            3'd2: begin
                hi_lo = 6'b01_10_00; // b high, c low
                idle_phase_o = 2'd0;
            end
            3'd3: begin
                hi_lo = 6'b00_10_01; // b high, a low
                idle_phase_o = 2'd2;
            end
            3'd4: begin
                hi_lo = 6'b10_00_01; // c high, a low
                idle_phase_o = 2'd1;
            end
            3'd5: begin
                hi_lo = 6'b10_01_00; // c high, b low
                idle_phase_o = 2'd0;
            end
            default: begin
                hi_lo = 6'h00;
                idle_phase_o = 2'd0;
            end
        endcase
    end
    // bipolar also enables the diagonal complementary pair of the idle-free legs
    always @* begin
        if (diagonal_switching_select_i) begin
            gate_pattern_o = hi_lo | {hi_lo[4], hi_lo[5], hi_lo[2], hi_lo[3], hi_lo[0], hi_lo[1]};
        end else begin
            gate_pattern_o = hi_lo;
        end
    end
    // idle phase input channel
    always @* begin
        case (idle_phase_o)
            2'd0:    emf_channel_o = `BSS_CH_PHASE_A;
            2'd1:    emf_channel_o = `BSS_CH_PHASE_B;
            2'd2:    emf_channel_o = `BSS_CH_PHASE_C;
            default: emf_channel_o = `BSS_CH_PHASE_A;
        endcase
    end
endmodule

// ### hw/bss_zero_detect.v
// zero crossing detector: sign change of emf minus half bus voltage
`timescale 1ns/1ps
module bss_zero_detect #(
    parameter W = 12
) (
    input  wire         clk_i,
    input  wire         rst_i,
    input  wire         restart_i,
    input  wire         sample_i,
    input  wire [W-1:0] emf_i,
    input  wire [W-1:0] bus_volt_i,
    output reg          cross_o
);
    // ****************************************************************
    // signed difference and sign history
    // ****************************************************************
    wire [W:0] diff = {1'b0, emf_i} - {2'b00, bus_volt_i[W-1:1]};
    wire       neg  = diff[W];
    reg        last_neg;
    reg        have_last;
    // flag either direction of sign change
    always @(posedge clk_i) begin
        if (rst_i) begin
            last_neg  <= 1'b0;
            have_last <= 1'b0;
            cross_o   <= 1'b0;
        end else begin
            cross_o <= 1'b0;
            if (restart_i) begin
                have_last <= 1'b0;
            end else if (sample_i) begin
                cross_o   <= have_last && (neg != last_neg);
                last_neg  <= neg;
                have_last <= 1'b1;
            end
        end
    end
endmodule

// ### hw/bss_sequencer.v
// back-emf and bus sampling sequencer with wishbone registers
// Operation
// - unipolar default, bipolar diagonal switching selectable
// - single conversions, right-justified twelve-bit results
// - emf conversions start only on pwm trigger, bus conversion on emf done
// - bus voltage channel 11, current 14
// - phase emf channels a10, b3, c7
// - emf channel follows idle phase of sector
// - store emf, poll bus conversion, detect, remap
// - emf sample instant aligned to pwm
// - zero crossing on sign change either way
// - sector steps zero to five, drives outputs
//
// Decided for this implementation: register access over Wishbone and the register addresses.
`timescale 1ns/1ps
module bss_sequencer #(
    parameter SW = 12
) (
    input  wire          clk_i,
    input  wire          rst_i,
    input  wire          wb_cyc_i,
    input  wire          wb_stb_i,
    input  wire          wb_we_i,
    input  wire [7:0]    wb_adr_i,
    input  wire [3:0]    wb_sel_i,
    input  wire [31:0]   wb_dat_i,
    output reg  [31:0]   wb_dat_o,
    output reg           wb_ack_o,
    input  wire          pwm_trigger_i,
    input  wire          commutate_i,
    output reg           adc_start_o,
    output reg  [3:0]    adc_channel_o,
    input  wire          adc_done_i,
    input  wire [15:0]   adc_result_i,
    output wire [5:0]    gate_pattern_o,
    output reg  [2:0]    commutation_sector_o,
    output reg           zero_cross_o,
    output wire          irq_o
);
`include "bss_map.vh"
    // ****************************************************************
    // state encoding
    // ****************************************************************
    localparam ST_IDLE = 2'd0;
    localparam ST_EMF  = 2'd1;
    localparam ST_BUS  = 2'd2;
    localparam ST_ZC   = 2'd3;

    reg  [3:0]    ctrl;
    reg  [1:0]    state;
    reg  [SW-1:0] emf_value;
    reg  [SW-1:0] bus_volt;
    reg  [SW-1:0] bus_cur;
    reg  [`BSS_IRQ_W-1:0] irq_stat;
    reg  [`BSS_IRQ_W-1:0] irq_en;
    reg           zc_sample;
    wire [3:0]    emf_channel;
    wire [1:0]    idle_phase;
    wire          zc_hit;
    wire          enable   = ctrl[`BSS_CTRL_ENABLE];
    wire          sec_cur  = ctrl[`BSS_CTRL_SEC_CUR];
    wire [SW-1:0] result   = adc_result_i[SW-1:0]; // right-justified low bits
    wire          wb_req   = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire          wb_wr    = wb_req && wb_we_i && wb_sel_i[0];
    wire          step_now = commutate_i ||
                             (wb_wr && wb_adr_i == `BSS_REG_CTRL && wb_dat_i[`BSS_CTRL_STEP]);
    wire          trig_ok  = enable && pwm_trigger_i && state == ST_IDLE; // busy triggers ignored
    wire          trig_bad = enable && pwm_trigger_i && state != ST_IDLE;

    // ****************************************************************
    // sector decode and detector
    // ****************************************************************
    bss_sector_map u_map (
        .commutation_sector_i        (commutation_sector_o),
        .diagonal_switching_select_i (ctrl[`BSS_CTRL_DIAGONAL]),
        .gate_pattern_o              (gate_pattern_o),
        .emf_channel_o               (emf_channel),
        .idle_phase_o                (idle_phase)
    );

    bss_zero_detect #(.W(SW)) u_zc (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .restart_i  (step_now),
        .sample_i   (zc_sample),
        .emf_i      (emf_value),
        .bus_volt_i (bus_volt),
        .cross_o    (zc_hit)
    );

    // ****************************************************************
    // commutation sector counter
    // ****************************************************************
    always @(posedge clk_i) begin
        if (rst_i) begin
            commutation_sector_o <= 3'd0;
        end else if (step_now) begin
            if (commutation_sector_o == `BSS_SECTOR_LAST) begin
                commutation_sector_o <= 3'd0;
            end else begin
                commutation_sector_o <= commutation_sector_o + 3'd1;
            end
        end
    end

    // ****************************************************************
    // conversion sequencer
    // ****************************************************************
    // emf start is registered, so it goes out the cycle after the trigger, one clock behind the pwm edge
    always @(posedge clk_i) begin
        if (rst_i) begin
            state         <= ST_IDLE;
            adc_start_o   <= 1'b0;
            adc_channel_o <= `BSS_CH_PHASE_A;
            emf_value     <= {SW{1'b0}};
            bus_volt      <= {SW{1'b0}};
            bus_cur       <= {SW{1'b0}};
            zc_sample     <= 1'b0;
        end else begin
            adc_start_o <= 1'b0;
            zc_sample   <= 1'b0;
            case (state)
                ST_IDLE: begin
                    adc_channel_o <= emf_channel; // channel remapped while idle
                    if (trig_ok) begin
                        adc_start_o   <= 1'b1; // one single conversion
                        adc_channel_o <= emf_channel;
                        state         <= ST_EMF;
                    end
                end
                ST_EMF: begin
                    if (adc_done_i) begin
                        emf_value     <= result;
                        adc_start_o   <= 1'b1;
                        adc_channel_o <= sec_cur ? `BSS_CH_BUS_CUR : `BSS_CH_BUS_VOLT;
                        state         <= ST_BUS;
                    end
                end
                ST_BUS: begin
                    if (adc_done_i) begin // polled completion
                        if (sec_cur) begin
                            bus_cur <= result;
                        end else begin
                            bus_volt <= result;
                        end
                        zc_sample <= 1'b1;
                        state     <= ST_ZC;
                    end
                end
                ST_ZC: begin
                    adc_channel_o <= emf_channel; // remap for next sample
                    state         <= ST_IDLE;
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // zero crossing output pulse
    always @(posedge clk_i) begin
        if (rst_i) begin
            zero_cross_o <= 1'b0;
        end else begin
            zero_cross_o <= zc_hit;
        end
    end

    // ****************************************************************
    // interrupt status, set wins over clear
    // ****************************************************************
    wire [`BSS_IRQ_W-1:0] irq_set = {trig_bad, zc_hit,
                                     (state == ST_BUS) && adc_done_i,
                                     (state == ST_EMF) && adc_done_i};
    wire [`BSS_IRQ_W-1:0] irq_clr = (wb_wr && wb_adr_i == `BSS_REG_IRQ_CLR) ?
                                    wb_dat_i[`BSS_IRQ_W-1:0] : {`BSS_IRQ_W{1'b0}};
    always @(posedge clk_i) begin
        if (rst_i) begin
            irq_stat <= {`BSS_IRQ_W{1'b0}};
        end else begin
            irq_stat <= (irq_stat & ~irq_clr) | irq_set; // dropped triggers logged
        end
    end
    assign irq_o = |(irq_stat & irq_en);

    // ****************************************************************
    // wishbone register writes
    // ****************************************************************
    always @(posedge clk_i) begin
        if (rst_i) begin
            ctrl   <= `BSS_CTRL_RESET; // unipolar after reset
            irq_en <= {`BSS_IRQ_W{1'b0}};
        end else if (wb_wr) begin
            case (wb_adr_i)
                `BSS_REG_CTRL:   ctrl   <= {1'b0, wb_dat_i[2:0]};
                `BSS_REG_IRQ_EN: irq_en <= wb_dat_i[`BSS_IRQ_W-1:0];
                default:         ctrl   <= ctrl;
            endcase
        end
    end

    // ****************************************************************
    // wishbone read and ack, one wait state
    // ****************************************************************
    always @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= wb_req;
            if (wb_req && !wb_we_i) begin
                case (wb_adr_i)
                    `BSS_REG_CTRL:     wb_dat_o <= {29'h0000_0000, ctrl[2:0]};
                    `BSS_REG_SECTOR:   wb_dat_o <= {27'h0000_000, idle_phase, commutation_sector_o};
                    `BSS_REG_EMF:      wb_dat_o <= {{(32-SW){1'b0}}, emf_value};
                    `BSS_REG_BUSV:     wb_dat_o <= {{(32-SW){1'b0}}, bus_volt};
                    `BSS_REG_BUSI:     wb_dat_o <= {{(32-SW){1'b0}}, bus_cur};
                    `BSS_REG_STATUS:   wb_dat_o <= {26'h000_0000, adc_channel_o, state};
                    `BSS_REG_IRQ_STAT: wb_dat_o <= {28'h000_0000, irq_stat};
                    `BSS_REG_IRQ_EN:   wb_dat_o <= {28'h000_0000, irq_en};
                    default:           wb_dat_o <= 32'h0000_0000;
                endcase
            end
        end
    end
endmodule

// ### bench/bss_sequencer_asserts.sv
// port-level checks of the sampling sequencer
`timescale 1ns/1ps
`include "bss_map.vh"
module bss_sequencer_asserts (
    input wire logic       clk_i,
    input wire logic       rst_i,
    input wire logic       wb_cyc_i,
    input wire logic       wb_stb_i,
    input wire logic       wb_ack_o,
    input wire logic       pwm_trigger_i,
    input wire logic       commutate_i,
    input wire logic       adc_start_o,
    input wire logic [3:0] adc_channel_o,
    input wire logic       adc_done_i,
    input wire logic [2:0] commutation_sector_o,
    input wire logic       zero_cross_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic [3:0] last_ch;
    logic       in_conv;
    // idle phase channel of a sector
    function automatic logic [3:0] emf_ch(input logic [2:0] s);
        case (s)
            3'd0, 3'd3: emf_ch = `BSS_CH_PHASE_C;
            3'd1, 3'd4: emf_ch = `BSS_CH_PHASE_B;
            default: emf_ch = `BSS_CH_PHASE_A;
        endcase
    endfunction
    // track the conversion in flight
    always @(posedge clk_i) begin
        if (rst_i) begin
            last_ch <= 4'h0;
            in_conv <= 1'b0;
        end else if (adc_start_o) begin
            last_ch <= adc_channel_o;
            in_conv <= 1'b1;
        end else if (adc_done_i) begin
            in_conv <= 1'b0;
        end
    end
    AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing one cycle after request");
    AST_ACK_DROP: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    AST_START_CAUSE: assert property (adc_start_o |-> $past(pwm_trigger_i) || $past(adc_done_i))
        else $error("conversion started without trigger");
    AST_START_PULSE: assert property (adc_start_o |=> !adc_start_o)
        else $error("start not a single pulse");
    AST_EMF_CH: assert property (adc_start_o && $past(pwm_trigger_i)
        |-> adc_channel_o == emf_ch(commutation_sector_o))
        else $error("emf channel does not match sector");
    AST_BUS_CH: assert property (adc_start_o && $past(adc_done_i)
        |-> adc_channel_o == `BSS_CH_BUS_VOLT || adc_channel_o == `BSS_CH_BUS_CUR)
        else $error("bus conversion on wrong channel");
    AST_BUS_NEXT: assert property (adc_done_i && in_conv && last_ch != `BSS_CH_BUS_VOLT
        && last_ch != `BSS_CH_BUS_CUR |=> adc_start_o)
        else $error("no bus conversion after emf sample");
    AST_TRIG_DROP: assert property (in_conv && !adc_done_i && pwm_trigger_i |=> !adc_start_o)
        else $error("trigger accepted while busy");
    AST_ZC_CAUSE: assert property (zero_cross_o |-> $past(adc_done_i, 3))
        else $error("zero cross not three cycles after bus result");
    AST_SECTOR_STEP: assert property (commutate_i |=> commutation_sector_o ==
        ($past(commutation_sector_o) == 3'd5 ? 3'd0 : $past(commutation_sector_o) + 3'd1))
        else $error("sector did not step");
    AST_SECTOR_MAX: assert property (commutation_sector_o <= 3'd5)
        else $error("sector out of range");
    COV_ZC: cover property (zero_cross_o);
    COV_CUR: cover property (adc_start_o && adc_channel_o == `BSS_CH_BUS_CUR);
    COV_DROP: cover property (in_conv && pwm_trigger_i);
endmodule
bind bss_sequencer bss_sequencer_asserts bss_sequencer_asserts_inst (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .pwm_trigger_i(pwm_trigger_i),
    .commutate_i(commutate_i), .adc_start_o(adc_start_o), .adc_channel_o(adc_channel_o),
    .adc_done_i(adc_done_i), .commutation_sector_o(commutation_sector_o), .zero_cross_o(zero_cross_o));

// ### bench/bss_adc_model.sv
// behavioural converter answering each start after a set latency
`timescale 1ns/1ps
`include "bss_map.vh"
module bss_adc_model (
    input  wire logic        clk_i,
    input  wire logic        start_i,
    input  wire logic [3:0]  channel_i,
    input  wire logic [7:0]  latency_i,
    input  wire logic [11:0] emf_val_i,
    input  wire logic [11:0] bus_val_i,
    output logic             done_o,
    output logic [15:0]      result_o
);
    logic [7:0] cnt = 8'h00;
    logic [3:0] ch = 4'h0;
    initial done_o = 1'b0;
    initial result_o = 16'h0000;
    // one result per start, junk in upper bits, result toggles outside done
    always @(posedge clk_i) begin
        done_o <= 1'b0;
        result_o <= ~result_o;
        if (start_i && cnt == 8'h00) begin
            cnt <= latency_i;
            ch <= channel_i;
        end else if (cnt == 8'h01) begin
            cnt <= 8'h00;
            done_o <= 1'b1;
            result_o <= {4'hA, (ch == `BSS_CH_BUS_VOLT || ch == `BSS_CH_BUS_CUR) ? bus_val_i : emf_val_i};
        end else if (cnt != 8'h00) begin
            cnt <= cnt - 8'h01;
        end
    end
endmodule

// ### bench/bss_sequencer_bench.sv
// self-checking bench of the sampling sequencer
`timescale 1ns/1ps
`include "bss_map.vh"
module bss_sequencer_bench;
    typedef struct packed {logic step; logic cur; logic [11:0] emf; logic [11:0] bus; logic [3:0] ch; logic zc;} bss_row_t;
    logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, trig = 0, comm = 0;
    logic [7:0] adr = 8'h00, lat = 8'h01;
    logic [31:0] wdat = 32'h0000_0000, rd;
    logic [11:0] emf_val = 12'h000, bus_val = 12'h000;
    logic [3:0] ch0, ch1;
    logic zc_seen;
    wire [31:0] wb_dat_o;
    wire [15:0] adc_result;
    wire [5:0] gate_pattern_o;
    wire [3:0] adc_channel_o;
    wire [2:0] sector;
    wire wb_ack_o, adc_start_o, adc_done, zero_cross_o, irq_o;
    int n_errors = 0, comparisons = 0, cycles = 0, n_start, n_done, i;
    bss_row_t rows [10] = '{'{0,0,12'h100,12'h400,7,0}, '{1,0,12'h300,12'h400,3,0}, '{1,0,12'h300,12'h400,10,0},
        '{1,0,12'h300,12'h400,7,0}, '{1,0,12'h300,12'h400,3,0}, '{1,0,12'h100,12'h400,10,0},
        '{0,0,12'h300,12'h400,10,1}, '{0,1,12'h0FF,12'h800,10,1}, '{0,0,12'h0FF,12'h400,10,0},
        '{1,0,12'h300,12'h400,7,0}};
    always #10 clk_i = ~clk_i;
    bss_sequencer bss_sequencer_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .pwm_trigger_i(trig), .commutate_i(comm), .adc_start_o(adc_start_o), .adc_channel_o(adc_channel_o),
        .adc_done_i(adc_done), .adc_result_i(adc_result), .gate_pattern_o(gate_pattern_o),
        .commutation_sector_o(sector), .zero_cross_o(zero_cross_o), .irq_o(irq_o));
    bss_adc_model bss_adc_model_inst (.clk_i(clk_i), .start_i(adc_start_o), .channel_i(adc_channel_o),
        .latency_i(lat), .emf_val_i(emf_val), .bus_val_i(bus_val), .done_o(adc_done), .result_o(adc_result));
    // ****
    // tasks
    // ****
    task finish_test;
        if (n_errors == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        cyc <= 1;
        stb <= 1;
        we <= w;
        adr <= a;
        wdat <= d;
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        cyc <= 0;
        stb <= 0;
    endtask
    task pulse_trig;
        @(posedge clk_i);
        trig <= 1;
        @(posedge clk_i);
        trig <= 0;
    endtask
    task run;
        n_start = 0;
        n_done = 0;
        zc_seen = 0;
        pulse_trig();
        while (n_done < 2) @(posedge clk_i);
        repeat (5) @(posedge clk_i); // zero cross pulse lands three edges after the bus result
    endtask
    // watchdog and converter traffic log
    always @(posedge clk_i) begin
        cycles++;
        if (adc_start_o === 1'b1) begin
            if (n_start == 0) ch0 = adc_channel_o; else ch1 = adc_channel_o;
            n_start++;
        end
        if (adc_done === 1'b1) n_done++;
        if (zero_cross_o === 1'b1) zc_seen = 1;
        if (cycles == 20000) begin
            n_errors++;
            finish_test();
        end
    end
    // ****
    // main sequence
    // ****
    initial begin
        repeat (16) @(posedge clk_i);
        rst_i <= 0;
        @(posedge clk_i);
        check("sector_rst", sector, 0);
        check("gate_rst", gate_pattern_o, 6'h06);
        check("irq_rst", irq_o, 0);
        wb(0, `BSS_REG_STATUS, 0);
        check("status_rst", rd, 32'h0000_001C);
        wb(0, `BSS_REG_CTRL, 0);
        check("ctrl_rst", rd, 0);
        for (i = 0; i < 10; i++) begin
            if (rows[i].step) begin
                @(posedge clk_i);
                comm <= 1;
                @(posedge clk_i);
                comm <= 0;
            end
            wb(1, `BSS_REG_CTRL, {29'h0, rows[i].cur, 2'b01});
            emf_val <= rows[i].emf;
            bus_val <= rows[i].bus;
            run();
            check("emf_channel", ch0, rows[i].ch);
            check("bus_channel", ch1, rows[i].cur ? 14 : 11);
            check("zero_cross", zc_seen, rows[i].zc);
            wb(0, `BSS_REG_EMF, 0);
            check("emf_reg", rd, rows[i].emf);
            wb(0, rows[i].cur ? `BSS_REG_BUSI : `BSS_REG_BUSV, 0);
            check("bus_reg", rd, rows[i].bus);
        end
        wb(1, `BSS_REG_CTRL, 3);
        check("gate_bipolar", gate_pattern_o, 6'h0F);
        wb(0, 8'h3C, 0);
        check("unmapped", rd, 0);
        wb(1, `BSS_REG_EMF, 32'h0000_0FFF);
        wb(0, `BSS_REG_EMF, 0);
        check("emf_ro", rd, 12'h300);
        wb(1, `BSS_REG_CTRL, 1);
        check("gate_unipolar", gate_pattern_o, 6'h06);
        lat <= 40;
        wb(1, `BSS_REG_IRQ_EN, 8);
        n_start = 0;
        n_done = 0;
        pulse_trig();
        repeat (5) @(posedge clk_i);
        pulse_trig();
        while (n_done < 2) @(posedge clk_i);
        repeat (3) @(posedge clk_i);
        check("drop_starts", n_start, 2);
        check("irq_drop", irq_o, 1);
        wb(1, `BSS_REG_IRQ_EN, 0);
        check("irq_masked", irq_o, 0);
        wb(1, `BSS_REG_IRQ_CLR, 8);
        wb(0, `BSS_REG_IRQ_STAT, 0);
        check("irq_clear", rd[3], 0);
        wb(1, `BSS_REG_IRQ_EN, 8);
        check("irq_after_clr", irq_o, 0);
        wb(1, `BSS_REG_CTRL, 0);
        n_start = 0;
        pulse_trig();
        repeat (10) @(posedge clk_i);
        check("disabled", n_start, 0);
        wb(1, `BSS_REG_CTRL, 8);
        @(posedge clk_i);
        check("step_bit", sector, 1);
        wb(0, `BSS_REG_SECTOR, 0);
        check("sector_reg", rd, 32'h0000_0009);
        wb(0, `BSS_REG_CTRL, 0);
        check("step_self_clear", rd, 0);
        finish_test();
    end
endmodule
